// file: design/ipr_cfg.svh
/*
  Constants of the interrupt priority resolver: register offsets, status word
  layout and reset value, source counts and the level code for a disabled source.
  Assumes inclusion by its bare name from the design files that need it.
*/
// Notes on behaviour
// - Level 3 is non-maskable and orders reset, stack error, illegal instruction, debug, trap, then the NMI.
// - Levels 0 to 2 are maskable, and external requests A, B, C, D win first within a level.
// - The six DMA channel requests come next, channel 0 highest and channel 5 lowest.
// - The host port follows as host command, then transmit empty, then receive full.
// - Serial port zero follows as rx exception, rx data, rx last slot, tx exception, tx last slot, tx data.
// - Serial port one ranks directly below port zero with the same internal order.
// - The async serial port follows as rx exception, rx data, tx data, idle line, then its timer.
// - Timers rank lowest, overflow before compare for timers 0, 1, 2, so timer 2 compare is last.
// - The two-bit core priority field codes 0 (00, lowest) to 3 (11, highest) and is compared with DMA priority.
// - The unnormalized flag becomes the XNOR of accumulator bits 47 and 46.
// - The scaling flag becomes the XOR of accumulator bits 46 and 45.
// - The 24-bit status word is read/write, resets to c00300, and its reserved bits are kept at zero.
`ifndef IPR_CFG_SVH
`define IPR_CFG_SVH

`define IPR_OFS_STATUS_WORD  32'h0000_0000
`define IPR_OFS_LEVEL_0      32'h0000_0004
`define IPR_OFS_LEVEL_1      32'h0000_0008
`define IPR_OFS_LEVEL_2      32'h0000_000c
`define IPR_OFS_WINNER       32'h0000_0010
`define IPR_OFS_EVT_STATUS   32'h0000_0014
`define IPR_OFS_EVT_CLEAR    32'h0000_0018
`define IPR_OFS_EVT_ENABLE   32'h0000_001c

`define IPR_SR_W             24
`define IPR_SR_RESET         24'hc0_0300
`define IPR_SR_WR_MASK       24'hfb_efff
`define IPR_SR_CP_LSB        22
`define IPR_SR_MASK_LSB      8
`define IPR_SR_SCALE_BIT     7
`define IPR_SR_UNNORM_BIT    4

`define IPR_ACC_W            48
`define IPR_ACC_TOP          47
`define IPR_ACC_MID          46
`define IPR_ACC_LOW          45

`define IPR_NUM_MASK         36
`define IPR_NUM_NMI          6
`define IPR_NUM_LVL_REGS     3
`define IPR_SRC_PER_REG      16
`define IPR_NUM_EVT          3
`define IPR_LVL_OFF          2'h3
`define IPR_LVL_NMI          2'h3
`define IPR_LVL_REG_RESET    32'hffff_ffff

`endif

// file: design/ipr_pkg.sv
/*
  Types of the interrupt priority resolver: request bundles in priority order,
  the APB carrier structs and the core-side request.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ipr_pkg;

  // fields listed highest priority first
  typedef struct packed {
    logic hw_reset;
    logic stack_error;
    logic illegal_instr;
    logic debug_req;
    logic trap;
    logic nmi;
  } ipr_nmi_src_s;

  typedef struct packed {
    logic [3:0] external_request;  // [0]=a .. [3]=d
    logic [5:0] dma_chan;          // [0]=channel 0
    logic       host_command;
    logic       host_tx_empty;
    logic       host_rx_full;
    logic [5:0] ssp0;              // [0]=rx exc,[1]=rx,[2]=rx last,[3]=tx exc,[4]=tx last,[5]=tx
    logic [5:0] ssp1;
    logic [4:0] async_port;        // [0]=rx exc,[1]=rx,[2]=tx,[3]=idle,[4]=timer
    logic [5:0] timer;             // [0]=t0 ovf,[1]=t0 cmp,[2]=t1 ovf,...,[5]=t2 cmp
  } ipr_mask_src_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } ipr_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ipr_apb_rsp_s;

  typedef struct packed {
    logic       valid;
    logic       nonmask;
    logic [1:0] level;
    logic [5:0] index;
  } ipr_core_req_s;

  typedef enum logic [1:0] {
    IPR_EVT_NMI_TAKEN,
    IPR_EVT_MASK_TAKEN,
    IPR_EVT_HELD_BY_MASK
  } ipr_evt_e;

endpackage

// file: design/ipr_first_set.sv
/*
  Fixed-order picker: finds the lowest set index of a request vector.
  Assumes index 0 is the highest priority position.
*/
`timescale 1ns/1ns
`default_nettype none
module ipr_first_set #(
  parameter int unsigned N  = 6,
  parameter int unsigned IW = 6
) (
  input  wire logic [N-1:0]  req_i,
  output logic               found_o,
  output logic [IW-1:0]      idx_o
);
  initial begin
    if (N < 1 || N > (1 << IW)) begin
      $error("ipr_first_set: N does not fit the index width");
    end
  end

  always_comb begin
    found_o = 1'b0;
    idx_o   = '0;
    // walk downward so the lowest set index is the last to assign
    for (int i = N - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        found_o = 1'b1;
        idx_o   = IW'(i);
      end
    end
  end
endmodule
`default_nettype wire

// file: design/ipr_event_bank.sv
/*
  Sticky event status with write-only clear, enable register and one level
  interrupt output. Assumes write strobes are single-cycle pulses.
*/
`timescale 1ns/1ns
`default_nettype none
module ipr_event_bank #(
  parameter int unsigned W = 3
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic         clr_wr_i,
  input  wire logic         en_wr_i,
  input  wire logic [W-1:0] wdata_i,
  output logic [W-1:0]      status_o,
  output logic [W-1:0]      enable_o,
  output logic              irq_o
);
  logic [W-1:0] status_q;
  logic [W-1:0] enable_q;

  initial begin
    if (W < 1 || W > 32) begin
      $error("ipr_event_bank: width must be 1 to 32");
    end
  end

  // a set in the clearing cycle survives
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~(clr_wr_i ? wdata_i : '0)) | set_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      enable_q <= '0;
    end else if (en_wr_i) begin
      enable_q <= wdata_i;
    end
  end

  assign status_o = status_q;
  assign enable_o = enable_q;
  assign irq_o    = |(status_q & enable_q);
endmodule
`default_nettype wire

// file: design/ipr_resolver.sv
/*
  Interrupt priority resolver: per-source level registers, level-then-order
  arbitration of maskable and non-maskable requests, core status word with
  accumulator-derived flags, APB register slave and event interrupt.
  Assumes request inputs are synchronous levels held until serviced, and an
  APB master that obeys setup and access phases.
*/
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "ipr_cfg.svh"
module ipr_resolver #(
  parameter int unsigned NUM_MASK = `IPR_NUM_MASK,
  parameter int unsigned NUM_NMI  = `IPR_NUM_NMI
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  input  wire ipr_pkg::ipr_apb_req_s  apb_req_i,
  output ipr_pkg::ipr_apb_rsp_s       apb_rsp_o,
  input  wire ipr_pkg::ipr_mask_src_s mask_src_i,
  input  wire ipr_pkg::ipr_nmi_src_s  nmi_src_i,
  input  wire logic                   acc_update_i,
  input  wire logic [`IPR_ACC_W-1:0]  acc_result_i,
  input  wire logic [1:0]             dma_prio_i,
  input  wire logic                   core_ack_i,
  output ipr_pkg::ipr_core_req_s      core_req_o,
  output logic [1:0]                  core_priority_o,
  output logic                        dma_over_core_o,
  output logic                        irq_o
);
  import ipr_pkg::*;

  initial begin
    if (NUM_MASK != $bits(ipr_mask_src_s) || NUM_NMI != $bits(ipr_nmi_src_s)) begin
      $error("ipr_resolver: source counts must match the request bundles");
    end
    if (NUM_MASK > `IPR_NUM_LVL_REGS * `IPR_SRC_PER_REG) begin
      $error("ipr_resolver: not enough level registers for NUM_MASK");
    end
  end

  // two-bit level of maskable source i inside the level register array
  function automatic logic [1:0] lvl_of(input logic [31:0] regs [`IPR_NUM_LVL_REGS], input int i);
    lvl_of = regs[i / `IPR_SRC_PER_REG][(i % `IPR_SRC_PER_REG) * 2 +: 2];
  endfunction

  logic [`IPR_SR_W-1:0] sr_q;
  logic [31:0]          lvl_q [`IPR_NUM_LVL_REGS];
  ipr_core_req_s        win_q;
  ipr_core_req_s        win_d;

  logic [NUM_MASK-1:0]  mask_vec;
  logic [NUM_NMI-1:0]   nmi_vec;
  logic [NUM_MASK-1:0]  per_lvl [3];
  logic [2:0]           lvl_found;
  logic [5:0]           lvl_idx [3];
  logic                 nmi_found;
  logic [5:0]           nmi_idx;
  logic [1:0]           sr_mask;
  logic                 held_by_mask;

  // apb decode
  logic                 apb_access;
  logic                 apb_wr;
  logic                 addr_hit;
  logic [31:0]          rd_data;
  logic [`IPR_NUM_EVT-1:0] evt_set;
  logic [`IPR_NUM_EVT-1:0] evt_status;
  logic [`IPR_NUM_EVT-1:0] evt_enable;
  logic                 evt_clr_wr;
  logic                 evt_en_wr;

  assign sr_mask = sr_q[`IPR_SR_MASK_LSB +: 2];

  // maskable requests in fixed order, index 0 highest
  always_comb begin
    mask_vec[3:0]   = mask_src_i.external_request;
    mask_vec[9:4]   = mask_src_i.dma_chan;
    mask_vec[10]    = mask_src_i.host_command;
    mask_vec[11]    = mask_src_i.host_tx_empty;
    mask_vec[12]    = mask_src_i.host_rx_full;
    mask_vec[18:13] = mask_src_i.ssp0;
    mask_vec[24:19] = mask_src_i.ssp1;
    mask_vec[29:25] = mask_src_i.async_port;
    mask_vec[35:30] = mask_src_i.timer;
  end

  // non-maskable requests, reset first and nmi last
  always_comb begin
    nmi_vec[0] = nmi_src_i.hw_reset;
    nmi_vec[1] = nmi_src_i.stack_error;
    nmi_vec[2] = nmi_src_i.illegal_instr;
    nmi_vec[3] = nmi_src_i.debug_req;
    nmi_vec[4] = nmi_src_i.trap;
    nmi_vec[5] = nmi_src_i.nmi;
  end

  // split pending maskable requests by their assigned level
  always_comb begin
    held_by_mask = 1'b0;
    for (int l = 0; l < 3; l++) begin
      per_lvl[l] = '0;
    end
    for (int i = 0; i < NUM_MASK; i++) begin
      for (int l = 0; l < 3; l++) begin
        // the off code never equals a maskable level
        if (mask_vec[i] && lvl_of(lvl_q, i) == 2'(l) && 2'(l) >= sr_mask) begin
          per_lvl[l][i] = 1'b1;
        end
      end
      if (mask_vec[i] && lvl_of(lvl_q, i) != `IPR_LVL_OFF && lvl_of(lvl_q, i) < sr_mask) begin
        held_by_mask = 1'b1;
      end
    end
  end

  for (genvar l = 0; l < 3; l++) begin : g_lvl
    ipr_first_set #(
      .N  (NUM_MASK),
      .IW (6)
    ) u_pick (
      .req_i   (per_lvl[l]),
      .found_o (lvl_found[l]),
      .idx_o   (lvl_idx[l])
    );
  end

  ipr_first_set #(
    .N  (NUM_NMI),
    .IW (6)
  ) u_nmi_pick (
    .req_i   (nmi_vec),
    .found_o (nmi_found),
    .idx_o   (nmi_idx)
  );

  // level decides first, fixed order only within the level
  always_comb begin
    win_d = '0;
    if (nmi_found) begin
      win_d.valid   = 1'b1;
      win_d.nonmask = 1'b1;
      win_d.level   = `IPR_LVL_NMI;
      win_d.index   = nmi_idx;
    end else if (lvl_found[2]) begin
      win_d.valid = 1'b1;
      win_d.level = 2'h2;
      win_d.index = lvl_idx[2];
    end else if (lvl_found[1]) begin
      win_d.valid = 1'b1;
      win_d.level = 2'h1;
      win_d.index = lvl_idx[1];
    end else if (lvl_found[0]) begin
      win_d.valid = 1'b1;
      win_d.level = 2'h0;
      win_d.index = lvl_idx[0];
    end
  end

  // registered winner: one cycle from request to core_req_o
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      win_q <= '0;
    end else begin
      win_q <= win_d;
    end
  end

  assign core_req_o = win_q;

  // apb slave, zero wait states
  assign apb_access = apb_req_i.psel && apb_req_i.penable;
  assign apb_wr     = apb_access && apb_req_i.pwrite;

  always_comb begin
    addr_hit = 1'b1;
    rd_data  = '0;
    unique case (apb_req_i.paddr)
      `IPR_OFS_STATUS_WORD: rd_data = {8'h00, sr_q};
      `IPR_OFS_LEVEL_0:     rd_data = lvl_q[0];
      `IPR_OFS_LEVEL_1:     rd_data = lvl_q[1];
      `IPR_OFS_LEVEL_2:     rd_data = lvl_q[2];
      `IPR_OFS_WINNER:      rd_data = {22'h00_0000, win_q};
      `IPR_OFS_EVT_STATUS:  rd_data = {29'h0000_0000, evt_status};
      `IPR_OFS_EVT_CLEAR:   rd_data = '0;
      `IPR_OFS_EVT_ENABLE:  rd_data = {29'h0000_0000, evt_enable};
      default:              addr_hit = 1'b0;
    endcase
  end

  always_comb begin
    apb_rsp_o.pready  = 1'b1;
    apb_rsp_o.pslverr = apb_access && !addr_hit;
    apb_rsp_o.prdata  = (apb_access && !apb_req_i.pwrite) ? rd_data : '0;
  end

  // status word: software write, then flags from the accumulator win
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sr_q <= `IPR_SR_RESET;
    end else begin
      if (apb_wr && apb_req_i.paddr == `IPR_OFS_STATUS_WORD) begin
        // reserved positions forced to zero whatever software writes
        sr_q <= apb_req_i.pwdata[`IPR_SR_W-1:0] & `IPR_SR_WR_MASK;
      end
      if (acc_update_i) begin
        sr_q[`IPR_SR_UNNORM_BIT] <= ~(acc_result_i[`IPR_ACC_TOP] ^ acc_result_i[`IPR_ACC_MID]);
        sr_q[`IPR_SR_SCALE_BIT]  <= acc_result_i[`IPR_ACC_MID] ^ acc_result_i[`IPR_ACC_LOW];
      end
    end
  end

  // level registers, all sources off after reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int r = 0; r < `IPR_NUM_LVL_REGS; r++) begin
        lvl_q[r] <= `IPR_LVL_REG_RESET;
      end
    end else if (apb_wr) begin
      if (apb_req_i.paddr == `IPR_OFS_LEVEL_0) begin
        lvl_q[0] <= apb_req_i.pwdata;
      end
      if (apb_req_i.paddr == `IPR_OFS_LEVEL_1) begin
        lvl_q[1] <= apb_req_i.pwdata;
      end
      if (apb_req_i.paddr == `IPR_OFS_LEVEL_2) begin
        lvl_q[2] <= apb_req_i.pwdata;
      end
    end
  end

  // core priority against the active dma channel priority
  assign core_priority_o = sr_q[`IPR_SR_CP_LSB +: 2];
  assign dma_over_core_o = dma_prio_i > core_priority_o;

  // events: taken request of each class, and a request held back by the mask
  always_comb begin
    evt_set                       = '0;
    evt_set[IPR_EVT_NMI_TAKEN]    = core_ack_i && win_q.valid && win_q.nonmask;
    evt_set[IPR_EVT_MASK_TAKEN]   = core_ack_i && win_q.valid && !win_q.nonmask;
    evt_set[IPR_EVT_HELD_BY_MASK] = held_by_mask;
  end

  assign evt_clr_wr = apb_wr && apb_req_i.paddr == `IPR_OFS_EVT_CLEAR;
  assign evt_en_wr  = apb_wr && apb_req_i.paddr == `IPR_OFS_EVT_ENABLE;

  ipr_event_bank #(
    .W (`IPR_NUM_EVT)
  ) u_events (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .set_i    (evt_set),
    .clr_wr_i (evt_clr_wr),
    .en_wr_i  (evt_en_wr),
    .wdata_i  (apb_req_i.pwdata[`IPR_NUM_EVT-1:0]),
    .status_o (evt_status),
    .enable_o (evt_enable),
    .irq_o    (irq_o)
  );
endmodule
`default_nettype wire

// file: bench/ipr_props.sv
/*
  Port-level checks of the interrupt priority resolver.
  Assumes a bind onto the resolver from the bench top file.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ipr_cfg.svh"
module ipr_props (
  input wire logic                   clk_i,
  input wire logic                   rst_n_i,
  input wire ipr_pkg::ipr_apb_req_s  apb_req_i,
  input wire ipr_pkg::ipr_apb_rsp_s  apb_rsp_o,
  input wire ipr_pkg::ipr_mask_src_s mask_src_i,
  input wire ipr_pkg::ipr_nmi_src_s  nmi_src_i,
  input wire logic                   acc_update_i,
  input wire logic [`IPR_ACC_W-1:0]  acc_result_i,
  input wire logic [1:0]             dma_prio_i,
  input wire logic                   core_ack_i,
  input wire ipr_pkg::ipr_core_req_s core_req_o,
  input wire logic [1:0]             core_priority_o,
  input wire logic                   dma_over_core_o,
  input wire logic                   irq_o
);
  import ipr_pkg::*;
  logic sr_wr;
  logic acc;
  assign sr_wr = apb_req_i.psel && apb_req_i.penable && apb_req_i.pwrite && apb_req_i.paddr == 32'h0;
  assign acc = apb_req_i.psel && apb_req_i.penable;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  pready_high_a: assert property (apb_rsp_o.pready)
    else $error("pready low");
  idle_quiet_a: assert property (!acc |-> !apb_rsp_o.pslverr && apb_rsp_o.prdata == 32'h0)
    else $error("response outside access");
  dma_compare_a: assert property (dma_over_core_o == (dma_prio_i > core_priority_o))
    else $error("dma compare wrong");
  cp_hold_a: assert property ($changed(core_priority_o) |-> $past(sr_wr))
    else $error("core priority moved without write");
  nmi_first_a: assert property (|nmi_src_i |=> core_req_o.valid && core_req_o.nonmask)
    else $error("nonmaskable not first");
  hw_reset_top_a: assert property (nmi_src_i.hw_reset |=> core_req_o.index == 6'h0)
    else $error("reset source not top");
  nmi_level_a: assert property (core_req_o.valid && core_req_o.nonmask |-> core_req_o.level == 2'h3)
    else $error("nonmaskable level wrong");
  off_never_a: assert property (core_req_o.valid && !core_req_o.nonmask |-> core_req_o.level != 2'h3)
    else $error("disabled source won");
  idle_none_a: assert property (!(|nmi_src_i) && !(|mask_src_i) |=> !core_req_o.valid)
    else $error("request with no source");
  c_nmi: cover property (core_req_o.valid && core_req_o.nonmask);
  c_mask: cover property (core_req_o.valid && !core_req_o.nonmask && core_ack_i);
  c_err: cover property (apb_rsp_o.pslverr);
endmodule
`default_nettype wire

// file: bench/ipr_src_model.sv
/*
  Peripheral sources and core: holds request levels, takes each winner.
  Assumes core_req_i in the resolver's index encoding.
*/
`timescale 1ns/1ns
`default_nettype none
module ipr_src_model (
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   load_i,
  input  wire logic [35:0]            mask_set_i,
  input  wire logic [5:0]             nmi_set_i,
  input  wire ipr_pkg::ipr_core_req_s core_req_i,
  output ipr_pkg::ipr_mask_src_s      mask_src_o,
  output ipr_pkg::ipr_nmi_src_s       nmi_src_o,
  output logic                        core_ack_o
);
  import ipr_pkg::*;
  // order index to bit of the packed bundle
  function automatic int pos(input int i);
    if (i < 4) return 32 + i;
    if (i < 10) return 22 + i;
    if (i < 13) return 35 - i;
    if (i < 19) return 4 + i;
    if (i < 25) return i - 8;
    if (i < 30) return i - 19;
    return i - 30;
  endfunction
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mask_src_o <= '0;
      nmi_src_o <= '0;
      core_ack_o <= 1'b0;
    end else begin
      core_ack_o <= 1'b0;
      if (load_i) begin
        mask_src_o <= mask_src_o | mask_set_i;
        nmi_src_o <= nmi_src_o | nmi_set_i;
      end else if (core_req_i.valid && !core_ack_o) begin
        // skip the stale cycle after an ack, the line drops one edge late
        core_ack_o <= 1'b1;
        if (core_req_i.nonmask) begin
          nmi_src_o[5 - core_req_i.index] <= 1'b0;
        end else begin
          mask_src_o[pos(core_req_i.index)] <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/tb_top.sv
/*
  Self-checking bench of the interrupt priority resolver over APB.
  Assumes the package, checker and source model compile first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import ipr_pkg::*;
  logic          clk_i = 1'b0;
  logic          rst_n_i = 1'b0;
  ipr_apb_req_s  req = '0;
  ipr_apb_rsp_s  rsp;
  ipr_mask_src_s msrc;
  ipr_nmi_src_s  nsrc;
  ipr_core_req_s creq;
  logic          upd = 1'b0;
  logic [47:0]   acc = '0;
  logic [1:0]    dprio = 2'h0;
  logic [1:0]    cprio;
  logic          ack, dover, irq, err;
  logic          load = 1'b0;
  logic [35:0]   mset = '0;
  logic [5:0]    nset = '0;
  logic [31:0]   rd, exp;
  int            n_errors = 0;
  int            comparisons = 0;
  always #10 clk_i = ~clk_i;
  ipr_resolver dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .apb_req_i(req), .apb_rsp_o(rsp),
    .mask_src_i(msrc), .nmi_src_i(nsrc), .acc_update_i(upd), .acc_result_i(acc), .dma_prio_i(dprio),
    .core_ack_i(ack), .core_req_o(creq), .core_priority_o(cprio), .dma_over_core_o(dover), .irq_o(irq));
  ipr_src_model src_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .load_i(load), .mask_set_i(mset),
    .nmi_set_i(nset), .core_req_i(creq), .mask_src_o(msrc), .nmi_src_o(nsrc), .core_ack_o(ack));
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_i);
    req.penable <= 1'b1;
    do @(posedge clk_i); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string w, input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(w, e, rd);
  endtask
  task automatic ld(input logic [35:0] m, input logic [5:0] n);
    @(posedge clk_i);
    mset <= m;
    nset <= n;
    load <= 1'b1;
    @(posedge clk_i);
    load <= 1'b0;
  endtask
  task automatic win(input logic [8:0] e);
    do @(posedge clk_i); while (ack !== 1'b1);
    chk("winner", {23'h0, e}, {23'h0, creq.nonmask, creq.level, creq.index});
  endtask
  task automatic print_verdict();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // about 200 cycles expected, twenty times that before giving up
  initial begin
    #80000;
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rdc("status word", 32'h0, 32'h00c00300);
    chk("core priority", 32'h3, {30'h0, cprio});
    rdc("level reg", 32'h4, 32'hffffffff);
    wr(32'h0, 32'h00ffffff);
    rdc("status word", 32'h0, 32'h00fbefff);
    wr(32'h0, 32'h0);
    dprio <= 2'h1;
    rdc("status word", 32'h0, 32'h0);
    chk("core priority", 32'h0, {30'h0, cprio});
    chk("dma over core", 32'h1, {31'h0, dover});
    for (int b = 0; b < 8; b++) begin
      @(posedge clk_i);
      acc <= {b[2:0], 45'h0};
      upd <= 1'b1;
      @(posedge clk_i);
      upd <= 1'b0;
      exp = 32'h0;
      exp[7] = b[1] ^ b[0];
      exp[4] = ~(b[2] ^ b[1]);
      rdc("acc flags", 32'h0, exp);
    end
    wr(32'h4, 32'h0);
    wr(32'h8, 32'h0);
    wr(32'hc, 32'hffffff80);
    wr(32'h1c, 32'h7);
    ld({36{1'b1}}, 6'h3f);
    for (int k = 0; k < 42; k++) begin
      win(k < 6 ? {2'b11, 1'b1, 6'(k)} : k == 6 ? {3'b010, 6'd35} : {3'b000, 6'(k - 7)});
    end
    rdc("events", 32'h14, 32'h3);
    chk("irq", 32'h1, {31'h0, irq});
    wr(32'h14, 32'h0);
    wr(32'h18, 32'h3);
    rdc("events", 32'h14, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    wr(32'h0, 32'h100);
    ld(36'h1 << 33, 6'h0);
    repeat (3) @(posedge clk_i);
    chk("held valid", 32'h0, {31'h0, creq.valid});
    rdc("events", 32'h14, 32'h4);
    chk("irq", 32'h1, {31'h0, irq});
    wr(32'h1c, 32'h0);
    rdc("enable", 32'h1c, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(32'h4, 32'h4);
    win({3'b001, 6'd1});
    rdc("unmapped", 32'h20, 32'h0);
    chk("slave error", 32'h1, {31'h0, err});
    print_verdict();
  end
endmodule
bind ipr_resolver ipr_props chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .apb_req_i(apb_req_i),
  .apb_rsp_o(apb_rsp_o), .mask_src_i(mask_src_i), .nmi_src_i(nmi_src_i), .acc_update_i(acc_update_i),
  .acc_result_i(acc_result_i), .dma_prio_i(dma_prio_i), .core_ack_i(core_ack_i), .core_req_o(core_req_o),
  .core_priority_o(core_priority_o), .dma_over_core_o(dma_over_core_o), .irq_o(irq_o));
`default_nettype wire
